// [core/i2c_port_cfg.svh]
// Constants of the serial register port: offsets, bit positions, resets
// and timing. Assumes the includer works at the system clock rate below.
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH

// ----------------------------------------------------------------------
// Bus address and register offsets
// ----------------------------------------------------------------------
`define DEV_ADDR        7'h34
`define REG_ID          8'h00
`define REG_INT_STATUS  8'h01
`define REG_TALLY       8'h02
`define REG_QUEUE_FIRST 8'h03
`define REG_QUEUE_LAST  8'h12
`define REG_INT_MODE    8'h3D
`define REG_INT_MASK    8'h3E

// ----------------------------------------------------------------------
// Field positions, reset values and queue depth
// ----------------------------------------------------------------------
`define BIT_EVENT       0
`define BIT_INPUT       1
`define BIT_OVERFLOW    2
`define BIT_REPULSE     0
`define MASK_RESET      8'h00
`define MODE_RESET      8'h00
`define QUEUE_DEPTH     5'h10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ         40
`define SCL_MAX_KHZ     1000
`define REPULSE_US      50
`define DEFER_MAX_US    23

`endif

// [core/i2c_port_pkg.sv]
// Types shared by the serial register port.
// Assumes nothing of its surroundings.
package i2c_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WR,
        ST_ACK,
        ST_RD,
        ST_MACK
    } port_state_t;

endpackage

// [core/reg_bus_if.sv]
// Carrier between the port controller and its register store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps

interface reg_bus_if #(parameter int AW = 6);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_data;

    modport ctl (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface

// [core/reg_store.sv]
// Byte-wide register store with one write port and a registered read.
// Assumes the controller keeps rd_addr steady a cycle before use.
`timescale 1ns/1ps

module reg_store #(
    parameter int AW = 6
) (
    input wire logic clk,    // System clock
    input wire logic rst_n,  // Asynchronous reset, active low
    reg_bus_if.mem   bus     // Store port
);
    logic [7:0] mem_q [2**AW];
    logic [7:0] rd_q;

    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= mem_q[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_q;
endmodule

// [core/i2c_register_port.sv]
// Serial register port: bus slave, event queue deferral, interrupt pin.
// Assumes SCL/SDA arrive from pins; event and input flags from own clock.
//
// Notes on behaviour
// - all registers reachable, SCL up to 1 MHz
// - answer only slave address 0x34
// - acknowledge matching address, pointer, data bytes
// - multibyte write stores then advances pointer
// - return pointed byte, advance after each
// - queue and tally updates wait during access
// - queue update may trail interrupt by 23us
// - interrupt pin low when enabled source active
// - register 0x3E masks sources onto pin
// - 0x3D selects hold or 50us release
// - any input interrupt sets input_change_flag
// - tally at 0x02 counts recorded queue entries
`timescale 1ns/1ps
`include "i2c_port_cfg.svh"

module i2c_register_port
    import i2c_port_pkg::*;
#(
    parameter int         GPI_N = 10,     // Input interrupt lines
    parameter logic [7:0] ID_VALUE = 8'hA5 // Arbitrary identity value
) (
    input  wire logic             CLK_SYS,           // 40 MHz clock
    input  wire logic             RSTN,              // Async reset, low
    input  wire logic             SCL_IN,            // Serial clock pin
    input  wire logic             SDA_IN,            // Serial data pin in
    output wire logic             SDA_OUT,           // Data drive level
    output wire logic             SDA_OE,            // Data pulls low
    output wire logic             INT_OUT,           // Interrupt level
    output wire logic             INT_OE,            // Interrupt pulls low
    input  wire logic             EVT_PUSH,          // New event pulse
    input  wire logic [7:0]       EVT_CODE,          // Event state and id
    input  wire logic [GPI_N-1:0] INPUT_CHANGE_FLAG_IN,        // Input interrupts
    output wire logic             HOLD_UPDATES,      // Queue access busy
    output wire logic [4:0]       QUEUE_ENTRY_TALLY, // Recorded entries
    output wire logic [2:0]       INT_STATUS         // Sticky flags
);
    localparam int REPULSE_CYC = `REPULSE_US * `CLK_MHZ;

    // ------------------------------------------------------------------
    // Address classes
    // ------------------------------------------------------------------
    function automatic logic in_zone(input logic [7:0] a);
        in_zone = (a >= `REG_TALLY) && (a <= `REG_QUEUE_LAST);
    endfunction

    function automatic logic read_only(input logic [7:0] a);
        read_only = (a == `REG_ID) || in_zone(a);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;

    // Fast-mode plus leaves 10+ system cycles per SCL level
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else begin
            {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, SCL_IN};
            {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, SDA_IN};
        end
    end

    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ------------------------------------------------------------------
    // Serial state
    // ------------------------------------------------------------------
    port_state_t st_q;
    port_state_t nxt_q;
    logic [7:0]  sh_q;
    logic [3:0]  cnt_q;
    logic [7:0]  ptr_q;
    logic        sda_oe_q;
    logic        nack_q;
    logic        sel_q;
    logic [7:0]  rdata_w;

    reg_bus_if #(.AW(6)) bus ();

    reg_store #(.AW(6)) u_store (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .bus   (bus)
    );

    wire byte_end = scl_fall && (cnt_q == 4'h8);
    wire addr_hit = (sh_q[7:1] == `DEV_ADDR);
    wire byte_w = (st_q == ST_WR) && byte_end;
    wire rd_done = (st_q == ST_RD) && scl_fall && (cnt_q == 4'h7);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            st_q     <= ST_IDLE;
            nxt_q    <= ST_IDLE;
            sh_q     <= 8'h00;
            cnt_q    <= 4'h0;
            ptr_q    <= 8'h00;
            sda_oe_q <= 1'b0;
            nack_q   <= 1'b0;
            sel_q    <= 1'b0;
        end else if (bus_stop) begin
            st_q     <= ST_IDLE;
            sda_oe_q <= 1'b0;
            sel_q    <= 1'b0;
        end else if (bus_start) begin
            st_q     <= ST_ADDR;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WR: begin
                    if (scl_rise && cnt_q != 4'h8) begin
                        sh_q  <= {sh_q[6:0], sda_s_q};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        sda_oe_q <= 1'b1;
                        st_q     <= ST_ACK;
                        if (st_q == ST_ADDR) begin
                            sda_oe_q <= addr_hit;
                            st_q     <= addr_hit ? ST_ACK : ST_IDLE;
                            sel_q    <= addr_hit;
                            nxt_q    <= sh_q[0] ? ST_RD : ST_PTR;
                        end else if (st_q == ST_PTR) begin
                            ptr_q <= sh_q;
                            nxt_q <= ST_WR;
                        end else begin
                            ptr_q <= ptr_q + 8'h01;
                            nxt_q <= ST_WR;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (nxt_q == ST_RD) begin
                            sh_q     <= rdata_w;
                            sda_oe_q <= ~rdata_w[7];
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                        st_q <= nxt_q;
                    end
                end
                ST_RD: begin
                    if (rd_done) begin
                        sda_oe_q <= 1'b0;
                        st_q     <= ST_MACK;
                        ptr_q    <= ptr_q + 8'h01;
                    end else if (scl_fall) begin
                        sh_q     <= {sh_q[6:0], 1'b0};
                        sda_oe_q <= ~sh_q[6];
                        cnt_q    <= cnt_q + 4'h1;
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s_q;
                    end else if (scl_fall) begin
                        // Not-acknowledge ends the read until the next start
                        st_q     <= nack_q ? ST_IDLE : ST_RD;
                        sh_q     <= rdata_w;
                        sda_oe_q <= ~nack_q & ~rdata_w[7];
                        cnt_q    <= 4'h0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register file around the store
    // ------------------------------------------------------------------
    logic [2:0] status_q;
    logic [4:0] tally_q;
    logic [7:0] mask_q;
    logic [7:0] mode_q;
    logic       hold_q;
    logic       pend_q;
    logic [7:0] pend_code_q;
    logic [GPI_N-1:0] gpi_q;

    wire in_map = (ptr_q[7:6] == 2'b00);
    wire host_we = byte_w && in_map && !read_only(ptr_q)
        && (ptr_q != `REG_INT_STATUS) && (ptr_q != `REG_INT_MODE)
        && (ptr_q != `REG_INT_MASK);
    wire w1c = byte_w && (ptr_q == `REG_INT_STATUS);
    wire [2:0] clr_w = w1c ? sh_q[2:0] : 3'h0;
    wire apply_w = pend_q && !hold_q && !host_we;
    wire room = tally_q < `QUEUE_DEPTH;
    wire [7:0] slot = `REG_QUEUE_FIRST + {3'h0, tally_q};
    wire [GPI_N-1:0] gpi_rise = INPUT_CHANGE_FLAG_IN & ~gpi_q;
    wire [2:0] set_w;

    assign set_w[`BIT_EVENT] = EVT_PUSH;
    assign set_w[`BIT_INPUT] = |gpi_rise;
    assign set_w[`BIT_OVERFLOW] = apply_w && !room;

    assign bus.wr_en = host_we || (apply_w && room);
    assign bus.wr_addr = host_we ? ptr_q[5:0] : slot[5:0];
    assign bus.wr_data = host_we ? sh_q : pend_code_q;
    assign bus.rd_addr = ptr_q[5:0];

    assign rdata_w =
        (ptr_q == `REG_ID)         ? ID_VALUE :
        (ptr_q == `REG_INT_STATUS) ? {5'h00, status_q} :
        (ptr_q == `REG_TALLY)      ? {3'h0, tally_q} :
        (ptr_q == `REG_INT_MODE)   ? mode_q :
        (ptr_q == `REG_INT_MASK)   ? mask_q :
        in_map                     ? bus.rd_data : 8'h00;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            status_q <= 3'h0;
            mask_q   <= `MASK_RESET;
            mode_q   <= `MODE_RESET;
            gpi_q    <= '0;
            hold_q   <= 1'b0;
        end else begin
            status_q <= (status_q & ~clr_w) | set_w; // Set beats clear
            if (byte_w && ptr_q == `REG_INT_MASK) mask_q <= sh_q;
            if (byte_w && ptr_q == `REG_INT_MODE) mode_q <= sh_q;
            gpi_q  <= INPUT_CHANGE_FLAG_IN;
            hold_q <= sel_q && in_zone(ptr_q);
        end
    end

    // Flag raised at once; entry lands once the host lets go
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            pend_q      <= 1'b0;
            pend_code_q <= 8'h00;
            tally_q     <= 5'h00;
        end else begin
            if (EVT_PUSH) begin
                pend_q      <= 1'b1;
                pend_code_q <= EVT_CODE;
            end else if (apply_w) begin
                pend_q <= 1'b0;
            end
            if (apply_w && room) begin
                tally_q <= tally_q + 5'h01;
            end else if (clr_w[`BIT_EVENT]) begin
                tally_q <= 5'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    logic [2:0]  src_q;
    logic [11:0] gap_q;

    wire [2:0] src_w = status_q & mask_q[2:0];
    wire int_act = |src_w;
    wire gap_go = mode_q[`BIT_REPULSE] && int_act && |(src_q & ~src_w);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            src_q <= 3'h0;
            gap_q <= 12'h000;
        end else begin
            src_q <= src_w;
            if (gap_go) begin
                gap_q <= 12'(REPULSE_CYC);
            end else if (gap_q != 12'h000) begin
                gap_q <= gap_q - 12'h001;
            end
        end
    end

    assign INT_OUT = 1'b0;
    assign INT_OE = int_act && (gap_q == 12'h000) && !gap_go;
    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_oe_q;
    assign HOLD_UPDATES = hold_q;
    assign QUEUE_ENTRY_TALLY = tally_q;
    assign INT_STATUS = status_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    chk_addr_miss: assert property (
        (st_q == ST_ADDR && byte_end && !addr_hit && !bus_stop
         && !bus_start) |=> (st_q == ST_IDLE) && !SDA_OE)
        else $error("foreign address was answered");
    chk_ack_drive: assert property (
        (st_q == ST_ACK) |-> SDA_OE || (nxt_q == ST_RD))
        else $error("acknowledge slot not driven low");
    chk_wr_step: assert property (
        (byte_w && !bus_stop && !bus_start)
        |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("write pointer did not advance");
    chk_rd_step: assert property (
        (rd_done && !bus_stop && !bus_start)
        |=> (st_q == ST_MACK) && (ptr_q == $past(ptr_q) + 8'h01))
        else $error("read pointer did not advance");
    chk_defer_hold: assert property (
        hold_q |-> !(bus.wr_en && !host_we))
        else $error("queue written during host access");
    chk_pend_apply: assert property (
        (apply_w && !EVT_PUSH) |=> !pend_q)
        else $error("released update not applied");
    chk_pin_gate: assert property (
        INT_OE |-> |(status_q & mask_q[2:0]))
        else $error("pin low with no enabled source");
    chk_repulse_gap: assert property (
        gap_go |=> !INT_OE [*8])
        else $error("pin not released after clear");
    chk_input_flag: assert property (
        (|gpi_rise) |=> status_q[`BIT_INPUT])
        else $error("input change flag not set");
    chk_tally_count: assert property (
        (apply_w && room) |=> tally_q == $past(tally_q) + 5'h01)
        else $error("tally not incremented");
    chk_ro_ignore: assert property (
        (byte_w && read_only(ptr_q)) |-> !host_we)
        else $error("read-only register written");
endmodule

// [bench/i2c_host_model.sv]
// Bus master model: start, stop, byte send and byte receive.
// Assumes a pull-up on SDA; the bench resolves the wired line.
`timescale 1ns/1ps

module i2c_host_model #(
    parameter int T = 50      // Quarter SCL period in ns
) (
    output logic      scl,    // Serial clock, idle high
    output logic      sda_lo, // High while pulling SDA low
    input  wire logic sda     // Resolved data line
);
    // ------------------------------------------
    // Bus phases
    // ------------------------------------------
    // 200 ns bit: four system cycles per level, still above the sync lag
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end

    task automatic start();
        sda_lo = 1'b0;
        #T scl = 1'b1;
        #T sda_lo = 1'b1;
        #T scl = 1'b0;
        #T;
    endtask

    task automatic stop();
        sda_lo = 1'b1;
        #T scl = 1'b1;
        #T sda_lo = 1'b0;
        #T;
    endtask

    // Data moves only while SCL is low, a quarter period after the fall
    task automatic bit_io(input logic v, output logic s);
        sda_lo = !v;
        #T scl = 1'b1;
        #T s = sda;
        #T scl = 1'b0;
        #T;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask

    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(last, s);
    endtask
endmodule

// [bench/i2c_register_port_tb_top.sv]
// Self-checking bench of the serial register port.
// Assumes the host model on the bus and a pull-up on SDA.
`timescale 1ns/1ps
`include "i2c_port_cfg.svh"

module i2c_register_port_tb_top;
    logic       clk;
    logic       rstn;
    logic       scl;
    logic       sda_lo;
    wire logic  sda;
    wire logic  sda_oe;
    wire logic  sda_out;
    wire logic  int_out;
    wire logic  int_oe;
    logic       evt_push;
    logic [7:0] evt_code;
    logic [9:0] gpi;
    wire logic  hold;
    wire logic [4:0] tally;
    wire logic [2:0] status;
    int         num_errors = 0;
    int         comparisons = 0;

    assign sda = !(sda_lo || (sda_oe && !sda_out));
    always #12.5 clk = ~clk;

    i2c_register_port i2c_register_port_i (
        .CLK_SYS(clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .INT_OUT(int_out),
        .INT_OE(int_oe),
        .EVT_PUSH(evt_push), .EVT_CODE(evt_code), .INPUT_CHANGE_FLAG_IN(gpi),
        .HOLD_UPDATES(hold), .QUEUE_ENTRY_TALLY(tally),
        .INT_STATUS(status));

    i2c_host_model i2c_host_model_i (.scl(scl), .sda_lo(sda_lo),
                                     .sda(sda));

    // ------------------------------------------
    // Shared tasks
    // ------------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // First byte of a burst sits in the top of d
    task automatic wr(input logic [7:0] p, input int n,
                      input logic [23:0] d);
        logic a;
        i2c_host_model_i.start();
        i2c_host_model_i.send({`DEV_ADDR, 1'b0}, a);
        check(8'(a), 8'h01);
        i2c_host_model_i.send(p, a);
        check(8'(a), 8'h01);
        for (int k = 0; k < n; k++) begin
            i2c_host_model_i.send(d[23-8*k -: 8], a);
            check(8'(a), 8'h01);
        end
        i2c_host_model_i.stop();
    endtask

    task automatic rd(input logic [7:0] p, input int n,
                      input logic [23:0] e);
        logic       a;
        logic [7:0] b;
        i2c_host_model_i.start();
        i2c_host_model_i.send({`DEV_ADDR, 1'b0}, a);
        i2c_host_model_i.send(p, a);
        check(8'(a), 8'h01);
        i2c_host_model_i.start();
        i2c_host_model_i.send({`DEV_ADDR, 1'b1}, a);
        check(8'(a), 8'h01);
        for (int k = 0; k < n; k++) begin
            i2c_host_model_i.recv(k == n - 1, b);
            check(b, e[23-8*k -: 8]);
        end
        i2c_host_model_i.stop();
    endtask

    task automatic push(input logic [7:0] code);
        @(negedge clk);
        evt_code = code;
        evt_push = 1'b1;
        @(negedge clk);
        evt_push = 1'b0;
    endtask

    // A wait that runs out ends the run at once
    task automatic wait_tally(input logic [4:0] v, input int lim);
        int i;
        i = 0;
        while (tally !== v && i < lim) begin
            @(negedge clk);
            i++;
        end
        check(8'(tally), 8'(v));
        if (i >= lim)
            finish_test();
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_config();
        wr(8'h3C, 3, 24'h11_00_07);
        rd(8'h3C, 3, 24'h11_00_07);
    endtask

    task automatic t_foreign();
        logic a;
        i2c_host_model_i.start();
        i2c_host_model_i.send({7'h35, 1'b0}, a);
        check(8'(a), 8'h00);
        i2c_host_model_i.send(8'h3C, a);
        i2c_host_model_i.send(8'h55, a);
        i2c_host_model_i.stop();
        rd(8'h3C, 1, 24'h11_0000);
    endtask

    task automatic t_readonly();
        wr(`REG_ID, 1, 24'h77_0000);
        rd(`REG_ID, 1, 24'hA5_0000);
        wr(`REG_QUEUE_LAST, 2, 24'h77_5C_00);
        rd(8'h13, 1, 24'h5C_0000);
    endtask

    task automatic t_events();
        logic a;
        push(8'h83);
        @(negedge clk);
        check(8'(tally), 8'h01);
        check(8'(status), 8'h01);
        check(8'(int_oe), 8'h01);
        i2c_host_model_i.start();
        i2c_host_model_i.send({`DEV_ADDR, 1'b0}, a);
        i2c_host_model_i.send(`REG_TALLY, a);
        check(8'(hold), 8'h01);
        push(8'h05);
        repeat (20) @(negedge clk);
        check(8'(tally), 8'h01);
        i2c_host_model_i.stop();
        wait_tally(5'h02, 920);
        rd(`REG_QUEUE_FIRST, 2, 24'h83_05_00);
        @(negedge clk);
        gpi[3] = 1'b1;
        @(negedge clk);
        check(8'(status), 8'h03);
        wr(`REG_INT_MASK, 1, 24'h00_0000);
        check(8'(int_oe), 8'h00);
    endtask

    task automatic t_repulse();
        wr(`REG_INT_MODE, 2, 24'h01_07_00);
        check(8'(int_oe), 8'h01);
        wr(`REG_INT_STATUS, 1, 24'h01_0000);
        check(8'(int_oe), 8'h00);
        check(8'(status), 8'h02);
        check(8'(tally), 8'h00);
        repeat (2100) @(negedge clk);
        check(8'(int_oe), 8'h01);
        wr(`REG_INT_MODE, 1, 24'h00_0000);
        push(8'h09);
        wr(`REG_INT_STATUS, 1, 24'h01_0000);
        check(8'(int_oe), 8'h01);
    endtask

    // Seventeenth entry finds the queue full: dropped, overflow raised
    task automatic t_overflow();
        for (int k = 0; k < 17; k++) begin
            push(8'(k));
        end
        @(negedge clk);
        check(8'(tally), 8'h10);
        check(8'(status), 8'h07);
        rd(`REG_QUEUE_LAST, 1, 24'h0F_0000);
    endtask

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        evt_push = 1'b0;
        evt_code = 8'h00;
        gpi = 10'h000;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        check({1'b0, sda_out, int_out, sda_oe, int_oe, hold, status[1:0]},
              8'h00);
        check({3'h0, tally}, 8'h00);
        t_config();
        t_foreign();
        t_readonly();
        t_events();
        t_repulse();
        t_overflow();
        finish_test();
    end
endmodule
